// file: core/dup_pkg.sv
// Shared constants for the bootstrap duplicator link
package dup_pkg;
    localparam int          CLK_HZ            = 25000000;
    localparam int          BAUD              = 115200;
    localparam int          BIT_CYCLES        = CLK_HZ / BAUD;
    localparam logic [7:0]  BAUD_CHAR         = 8'hFF;
    localparam logic [7:0]  READY_CHAR        = 8'hFF;
    localparam int          PAUSE_BITS        = 40;
    localparam int          VPP_STABLE_MS     = 200;
    localparam int          VPP_STABLE_CYCLES = (CLK_HZ / 1000) * VPP_STABLE_MS;
    localparam int          IMAGE_BYTES       = 12288;
    localparam int          PROG_TIME_CYCLES  = 50;
    localparam logic [15:0] PROG_START_ADDR   = 16'hD000;
    localparam logic [15:0] EEPROM_START_ADDR = 16'hB600;
    localparam int          STUB_LEN          = 4;
endpackage : dup_pkg

// file: core/dup_link_if.sv
// Serial link and control wires between host and target
`timescale 1ns/100ps
interface dup_link_if;
    logic host_tx;
    logic target_tx_out;
    logic target_tx_oe;
    logic target_reset_drive;
    logic target_rx_oe;
    wire  target_tx_line = target_tx_oe ? target_tx_out : 1'b1;
    modport host (output host_tx, output target_reset_drive,
                  input target_tx_out, input target_tx_oe, input target_tx_line);
    modport target (input host_tx, input target_reset_drive,
                    output target_tx_out, output target_tx_oe, output target_rx_oe);
endinterface : dup_link_if

// file: core/dup_target.sv
// Target end: bootstrap loader and byte programming utility
//
// Summary of operation
// - Send break first after leaving reset
// - Boot sets port D open-drain select
// - Other port D pins stay inputs
// - Serial pins undriven while in reset
// - Break as first char jumps EEPROM
// - Host holds target reset from start
// - Host waits for target break
// - Host leads with all-ones baud char
// - Pause after program ends load
// - Keep serial on, preset time, address
// - Stub clears open-drain, enters utility
// - Host senses voltage presence only
// - Host waits 200 ms stable voltage
// - Program, read back, echo each byte
// - Host aborts on mismatch, LEDs off
// - Host signals success after 12 Kbytes
// - Reset, modes low: emulation mode
// - Mode pins sampled only during reset
// - Utility sends all-ones when ready
`timescale 1ns/100ps
module dup_target (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    dup_link_if.target       link,
    input  wire logic        mode_select_a,
    input  wire logic        mode_select_b,
    output logic             emulation_mode,
    output logic             port_d_open_drain_select,
    output logic             eeprom_jump,
    output logic [15:0]      prog_addr,
    output logic [7:0]       prog_data,
    output logic             prog_strobe
);
    typedef enum logic [8:0] {
        S_RESET = 9'h001, S_BREAK = 9'h002, S_BAUD  = 9'h004,
        S_LOAD  = 9'h008, S_STUB  = 9'h010, S_READY = 9'h020,
        S_WAIT  = 9'h040, S_PROG  = 9'h080, S_ECHO  = 9'h100
    } tstate_e;

    tstate_e     state;
    logic        rx_m, rx_s, rst_m, rst_s, ma_m, ma_s, mb_m, mb_s;
    logic [1:0]  mode_latched;
    logic [15:0] cnt;
    logic [7:0]  mem [0:255];
    logic [7:0]  stub_cnt;
    logic        first_char;
    // Receiver
    logic        rx_busy;
    logic [3:0]  rx_bit;
    logic [15:0] rx_cnt;
    logic [7:0]  rx_sh;
    logic        rx_done;
    logic        rx_break;
    logic [7:0]  rx_data;
    logic [15:0] idle_cnt;
    // Transmitter
    logic        tx_busy;
    logic [3:0]  tx_bit;
    logic [15:0] tx_cnt;
    logic [9:0]  tx_sh;
    logic        tx_start;
    logic [9:0]  tx_frame;
    logic        in_reset;
    logic        pause_seen;

    always_ff @(posedge clk) begin
        rx_m  <= link.host_tx;
        rx_s  <= rx_m;
        rst_m <= link.target_reset_drive;
        rst_s <= rst_m;
        ma_m  <= mode_select_a;
        ma_s  <= ma_m;
        mb_m  <= mode_select_b;
        mb_s  <= mb_m;
    end

    assign in_reset = sys_rst | ~rst_s;
    // Held off in the first cycle out of reset, before wire-OR is on
    assign link.target_tx_oe  = ~in_reset & (state != S_RESET)
                                & (~port_d_open_drain_select | ~tx_sh[0]);
    assign link.target_rx_oe  = 1'b0;
    assign link.target_tx_out = tx_sh[0];
    assign emulation_mode = in_reset & (mode_latched == 2'b00);
    assign pause_seen = (idle_cnt >= 16'(dup_pkg::PAUSE_BITS * dup_pkg::BIT_CYCLES));

    // Mode pins latched only while reset held
    always_ff @(posedge clk) begin
        if (in_reset) begin
            mode_latched <= {mb_s, ma_s};
        end
    end

    // Receiver, 8N1; all-zero frame flags break
    always_ff @(posedge clk) begin
        rx_done  <= 1'b0;
        if (in_reset) begin
            rx_busy  <= 1'b0;
            rx_cnt   <= '0;
            rx_bit   <= '0;
            idle_cnt <= '0;
            rx_break <= 1'b0;
            rx_data  <= 8'h00;
            rx_sh    <= 8'h00;
        end else if (!rx_busy) begin
            if (!rx_s) begin
                rx_busy  <= 1'b1;
                rx_cnt   <= 16'(dup_pkg::BIT_CYCLES / 2);
                rx_bit   <= '0;
                idle_cnt <= '0;
            end else if (!pause_seen) begin
                idle_cnt <= idle_cnt + 16'd1;
            end
        end else if (rx_cnt == 16'd0) begin
            rx_cnt <= 16'(dup_pkg::BIT_CYCLES - 1);
            rx_bit <= rx_bit + 4'd1;
            if (rx_bit >= 4'd1 && rx_bit <= 4'd8) begin
                rx_sh <= {rx_s, rx_sh[7:1]};
            end
            if (rx_bit == 4'd9) begin
                rx_busy  <= 1'b0;
                rx_done  <= 1'b1;
                rx_data  <= rx_sh;
                rx_break <= ~rx_s & (rx_sh == 8'h00);
            end
        end else begin
            rx_cnt <= rx_cnt - 16'd1;
        end
    end

    // Transmitter; all-zero frame with low stop is a break
    always_ff @(posedge clk) begin
        if (in_reset) begin
            tx_busy <= 1'b0;
            tx_sh   <= 10'h3FF;
            tx_cnt  <= '0;
            tx_bit  <= '0;
        end else if (tx_start && !tx_busy) begin
            tx_busy <= 1'b1;
            tx_sh   <= tx_frame;
            tx_cnt  <= 16'(dup_pkg::BIT_CYCLES - 1);
            tx_bit  <= '0;
        end else if (tx_busy) begin
            if (tx_cnt == 16'd0) begin
                tx_cnt <= 16'(dup_pkg::BIT_CYCLES - 1);
                tx_sh  <= {1'b1, tx_sh[9:1]};
                tx_bit <= tx_bit + 4'd1;
                if (tx_bit == 4'd9) begin
                    tx_busy <= 1'b0;
                end
            end else begin
                tx_cnt <= tx_cnt - 16'd1;
            end
        end
    end

    assign tx_start = (state == S_BREAK) || (state == S_READY)
                      || (state == S_ECHO && cnt == 16'd0);
    assign tx_frame = (state == S_BREAK) ? 10'h000 :
                      (state == S_READY) ? {1'b1, dup_pkg::READY_CHAR, 1'b0} :
                      {1'b1, mem[8'hFF], 1'b0};

    // Boot sequence and programming utility
    always_ff @(posedge clk) begin
        prog_strobe <= 1'b0;
        if (in_reset) begin
            state       <= S_RESET;
            port_d_open_drain_select <= 1'b0;
            eeprom_jump <= 1'b0;
            prog_addr   <= dup_pkg::PROG_START_ADDR;
            prog_data   <= 8'h00;
            cnt         <= '0;
            stub_cnt    <= '0;
            first_char  <= 1'b1;
        end else begin
            unique case (state)
                S_RESET: begin
                    port_d_open_drain_select <= 1'b1;
                    state <= S_BREAK;
                end
                S_BREAK: if (!tx_busy) state <= S_BAUD;
                S_BAUD: if (rx_done) begin
                    if (rx_break && first_char) begin
                        eeprom_jump <= 1'b1;
                        prog_addr   <= dup_pkg::EEPROM_START_ADDR;
                        state       <= S_RESET;
                    end else begin
                        first_char <= 1'b0;
                        state      <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    if (rx_done) begin
                        mem[stub_cnt] <= rx_data;
                        stub_cnt      <= stub_cnt + 8'd1;
                    end else if (pause_seen && stub_cnt != 8'd0) begin
                        state <= S_STUB;
                    end
                end
                S_STUB: begin
                    // Downloaded stub modeled as clearing open-drain select
                    port_d_open_drain_select <= 1'b0;
                    prog_addr <= dup_pkg::PROG_START_ADDR;
                    state     <= S_READY;
                end
                S_READY: state <= S_WAIT;
                S_WAIT: if (rx_done) begin
                    prog_data   <= rx_data;
                    prog_strobe <= 1'b1;
                    mem[8'hFF]  <= rx_data;
                    cnt         <= 16'(dup_pkg::PROG_TIME_CYCLES);
                    state       <= S_PROG;
                end
                S_PROG: begin
                    if (cnt == 16'd0) state <= S_ECHO;
                    else cnt <= cnt - 16'd1;
                end
                S_ECHO: if (!tx_busy) begin
                    prog_addr <= prog_addr + 16'd1;
                    state     <= S_WAIT;
                end
                default: state <= S_RESET;
            endcase
        end
    end
endmodule : dup_target

// file: core/dup_host.sv
// Host end: drives target reset, download and byte verify
`timescale 1ns/100ps
module dup_host #(
    parameter int VPP_CYCLES = dup_pkg::VPP_STABLE_CYCLES,
    parameter int IMG_BYTES  = dup_pkg::IMAGE_BYTES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    dup_link_if.host         link,
    input  wire logic        prog_voltage_sense,
    input  wire logic        start,
    input  wire logic [7:0]  img_data,
    output logic [15:0]      img_index,
    output logic             busy_led,
    output logic             done_led
);
    typedef enum logic [7:0] {
        H_IDLE = 8'h01, H_BRK = 8'h02, H_BAUD = 8'h04, H_STUB = 8'h08,
        H_PAUSE = 8'h10, H_VPP = 8'h20, H_SEND = 8'h40, H_VERIFY = 8'h80
    } hstate_e;

    hstate_e     state;
    logic        rx_m, rx_s, vp_m, vp_s;
    logic [31:0] cnt;
    logic [7:0]  sent;
    logic [2:0]  stub_i;
    logic        rx_busy, rx_done;
    logic [3:0]  rx_bit;
    logic [15:0] rx_cnt;
    logic [7:0]  rx_sh, rx_data;
    logic        tx_busy, tx_go;
    logic [3:0]  tx_bit;
    logic [15:0] tx_cnt;
    logic [9:0]  tx_sh;
    logic [7:0]  tx_byte;

    always_ff @(posedge clk) begin
        rx_m <= link.target_tx_line;
        rx_s <= rx_m;
        vp_m <= prog_voltage_sense;
        vp_s <= vp_m;
    end

    assign link.host_tx = tx_sh[0];

    always_ff @(posedge clk) begin
        rx_done <= 1'b0;
        if (sys_rst) begin
            rx_busy <= 1'b0;
            rx_bit  <= '0;
            rx_cnt  <= '0;
            rx_sh   <= 8'h00;
            rx_data <= 8'h00;
        end else if (!rx_busy) begin
            if (!rx_s) begin
                rx_busy <= 1'b1;
                rx_cnt  <= 16'(dup_pkg::BIT_CYCLES / 2);
                rx_bit  <= '0;
            end
        end else if (rx_cnt == 16'd0) begin
            rx_cnt <= 16'(dup_pkg::BIT_CYCLES - 1);
            rx_bit <= rx_bit + 4'd1;
            if (rx_bit >= 4'd1 && rx_bit <= 4'd8) rx_sh <= {rx_s, rx_sh[7:1]};
            if (rx_bit == 4'd9 && rx_s) begin
                rx_busy <= 1'b0;
                rx_done <= 1'b1;
                rx_data <= rx_sh;
            end else if (rx_bit == 4'd9) begin
                // Break: flag it, then wait for line high before rearming
                rx_done <= 1'b1;
                rx_data <= 8'h00;
                rx_bit  <= 4'd10;
                rx_cnt  <= 16'd0;
            end else if (rx_bit == 4'd10) begin
                rx_bit <= 4'd10;
                rx_cnt <= 16'd0;
                if (rx_s) rx_busy <= 1'b0;
            end
        end else begin
            rx_cnt <= rx_cnt - 16'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_busy <= 1'b0;
            tx_sh   <= 10'h3FF;
            tx_cnt  <= '0;
            tx_bit  <= '0;
        end else if (tx_go && !tx_busy) begin
            tx_busy <= 1'b1;
            tx_sh   <= {1'b1, tx_byte, 1'b0};
            tx_cnt  <= 16'(dup_pkg::BIT_CYCLES - 1);
            tx_bit  <= '0;
        end else if (tx_busy) begin
            if (tx_cnt == 16'd0) begin
                tx_cnt <= 16'(dup_pkg::BIT_CYCLES - 1);
                tx_sh  <= {1'b1, tx_sh[9:1]};
                tx_bit <= tx_bit + 4'd1;
                if (tx_bit == 4'd9) tx_busy <= 1'b0;
            end else tx_cnt <= tx_cnt - 16'd1;
        end
    end

    assign tx_go = (state == H_BAUD) || (state == H_STUB) || (state == H_SEND);
    assign tx_byte = (state == H_BAUD) ? dup_pkg::BAUD_CHAR :
                     (state == H_STUB) ? {5'h00, stub_i} : img_data;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= H_IDLE;
            link.target_reset_drive <= 1'b0;
            cnt       <= '0;
            sent      <= 8'h00;
            stub_i    <= '0;
            img_index <= '0;
            busy_led  <= 1'b0;
            done_led  <= 1'b0;
        end else begin
            unique case (state)
                H_IDLE: if (start) begin
                    link.target_reset_drive <= 1'b1;
                    state <= H_BRK;
                end
                H_BRK: if (rx_done) state <= H_BAUD;
                H_BAUD: if (!tx_busy) state <= H_STUB;
                H_STUB: if (!tx_busy) begin
                    if (stub_i == 3'(dup_pkg::STUB_LEN - 1)) begin
                        state <= H_PAUSE;
                        cnt   <= '0;
                    end else stub_i <= stub_i + 3'd1;
                end
                H_PAUSE: if (rx_done) begin // Ready char marks stub ran
                    state <= H_VPP;
                    cnt   <= '0;
                end
                H_VPP: begin
                    if (!vp_s) cnt <= '0;
                    else if (cnt >= 32'(VPP_CYCLES)) begin
                        busy_led <= 1'b1;
                        state    <= H_SEND;
                    end else cnt <= cnt + 32'd1;
                end
                H_SEND: if (!tx_busy) begin
                    sent  <= img_data;
                    state <= H_VERIFY;
                end
                H_VERIFY: if (rx_done) begin
                    if (rx_data != sent) begin
                        busy_led <= 1'b0;
                        done_led <= 1'b0;
                        state    <= H_IDLE;
                    end else if (img_index == 16'(IMG_BYTES - 1)) begin
                        busy_led <= 1'b0;
                        done_led <= 1'b1;
                        state    <= H_IDLE;
                    end else begin
                        img_index <= img_index + 16'd1;
                        state     <= H_SEND;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule : dup_host

// file: bench/dup_link_assertions.sv
// Checker for the host to target bootstrap link
`timescale 1ns/100ps
module dup_link_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic host_tx,
    input wire logic target_tx_out,
    input wire logic target_tx_oe,
    input wire logic target_reset_drive,
    input wire logic target_rx_oe,
    input wire logic target_tx_line
);
    localparam int BT = dup_pkg::BIT_CYCLES;
    int   tlow;
    int   hlow;
    logic brk_done;
    logic t_one;
    logic h_seen;
    logic h_one;
    wire  clr = sys_rst || !target_reset_drive;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Break counts as seen at 9 bits, where a receiver may already flag it
    always_ff @(posedge clk) begin
        tlow     <= (clr || target_tx_line) ? 0 : tlow + 1;
        hlow     <= (clr || host_tx) ? 0 : hlow + 1;
        brk_done <= !clr && (brk_done || tlow >= 9 * BT);
        t_one    <= !clr && (t_one || (target_tx_line && tlow != 0));
        h_seen   <= !clr && (h_seen || !host_tx);
        h_one    <= !clr && (h_one || (host_tx && hlow != 0));
    end

    a_rx_pin_quiet: assert property (target_rx_oe == 1'b0)
        else $error("target rx pin driven");
    a_tx_quiet_reset: assert property (!target_reset_drive [*5] |-> !target_tx_oe)
        else $error("target tx driven in reset");
    a_reset_from_start: assert property ($fell(sys_rst) |-> !target_reset_drive)
        else $error("target not held after reset");
    a_host_waits_break: assert property (!brk_done |-> host_tx)
        else $error("host sent before break");
    a_break_length: assert property ($rose(target_tx_line) && !t_one |-> tlow >= 10*BT-2)
        else $error("first target char not a break");
    a_wire_or_tx: assert property (!h_seen && target_tx_oe |-> !target_tx_out)
        else $error("target drove high in wire-or mode");
    a_baud_char: assert property ($rose(host_tx) && !h_one |-> hlow inside {[BT-2:BT+2]})
        else $error("first host char not all ones");
    a_host_framing: assert property ($rose(host_tx) |-> hlow inside {[BT-2:9*BT+2]})
        else $error("host low run breaks framing");

    c_break: cover property ($rose(target_tx_line) && !t_one);
    c_baud: cover property ($rose(host_tx) && !h_one);
    c_driven_high: cover property (target_tx_oe && target_tx_out);
endmodule : dup_link_assertions

// file: bench/test_bootstrap_eprom_duplicator.sv
// Self-checking bench for the host and target pair
`timescale 1ns/100ps
module test_bootstrap_eprom_duplicator;
    localparam int BT = dup_pkg::BIT_CYCLES;
    localparam int VPP_N = 100;
    localparam int IMG_N = 3;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        start = 1'b0;
    logic        sense = 1'b0;
    logic        mode_select_a = 1'b0;
    logic        mode_select_b = 1'b0;
    logic [7:0]  image [IMG_N];
    logic [15:0] img_index;
    logic        busy_led;
    logic        done_led;
    logic        emulation_mode;
    logic        open_drain;
    logic        eeprom_jump;
    logic [15:0] prog_addr;
    logic [7:0]  prog_data;
    logic        prog_strobe;
    logic [15:0] s_addr [$];
    logic [7:0]  s_data [$];
    logic [7:0]  b;
    int          n;
    int          cyc = 0;
    int          fails = 0;
    int          tests_run = 0;

    dup_link_if link ();
    dup_host #(.VPP_CYCLES(VPP_N), .IMG_BYTES(IMG_N)) dup_host_inst (.clk(clk),
        .sys_rst(sys_rst), .link(link.host), .prog_voltage_sense(sense), .start(start),
        .img_data(image[img_index[1:0]]), .img_index(img_index), .busy_led(busy_led),
        .done_led(done_led));
    dup_target dup_target_inst (.clk(clk), .sys_rst(sys_rst), .link(link.target),
        .mode_select_a(mode_select_a), .mode_select_b(mode_select_b),
        .emulation_mode(emulation_mode), .port_d_open_drain_select(open_drain),
        .eeprom_jump(eeprom_jump), .prog_addr(prog_addr), .prog_data(prog_data),
        .prog_strobe(prog_strobe));
    dup_link_assertions dup_link_assertions_inst (.clk(clk), .sys_rst(sys_rst),
        .host_tx(link.host_tx), .target_tx_out(link.target_tx_out),
        .target_tx_oe(link.target_tx_oe), .target_reset_drive(link.target_reset_drive),
        .target_rx_oe(link.target_rx_oe), .target_tx_line(link.target_tx_line));

    initial begin
        forever #20 clk = ~clk;
    end

    // Ceiling is about twice the 170 bit times the run should take
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (prog_strobe === 1'b1) begin
            s_addr.push_back(prog_addr);
            s_data.push_back(prog_data);
        end
        if (cyc == 80000) begin
            fails++;
            final_report();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic chk_min(input int got, input int lo, input string m);
        tests_run++;
        if (got < lo) begin
            fails++;
            $display("CHECK FAILED t=%0t %s %0d below %0d", $time, m, got, lo);
        end
    endtask : chk_min

    function automatic logic line(input bit tgt);
        return tgt ? link.target_tx_line : link.host_tx;
    endfunction : line

    task automatic wait_low(input bit tgt, input int lim, output int c);
        c = 0;
        while (line(tgt) !== 1'b0 && c < lim) begin
            @(posedge clk);
            c++;
        end
    endtask : wait_low

    // Samples mid-bit, away from the line's own edges
    task automatic rx(input bit tgt, output logic [7:0] d);
        int c;
        wait_low(tgt, 60 * BT, c);
        repeat (BT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BT) @(posedge clk);
            d[i] = line(tgt);
        end
        repeat (BT) @(posedge clk);
        chk(line(tgt), 1'b1, "stop bit");
    endtask : rx

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    initial begin
        void'($urandom(32'h5706));
        image[0] = 8'hFF;
        image[1] = 8'h00;
        image[2] = 8'($urandom);
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(link.target_reset_drive, 1'b0, "target reset");
        chk(emulation_mode, 1'b1, "emulation");
        chk(link.target_tx_oe, 1'b0, "tx in reset");
        repeat ($urandom_range(20, 3)) @(posedge clk);
        chk(link.target_reset_drive, 1'b0, "reset before start");
        $display("test reset done");
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wait_low(1, 60 * BT, n);
        // Host answers before the break ends, so both lines are watched at once
        fork
            begin
                n = 0;
                while (link.target_tx_line === 1'b0 && n < 12 * BT) begin
                    @(posedge clk);
                    n++;
                end
                chk_min(n, 10 * BT - 2, "break length");
                chk(open_drain, 1'b1, "wire-or set");
                chk(emulation_mode, 1'b0, "mode after release");
            end
            rx(0, b);
        join
        mode_select_a <= 1'($urandom);
        mode_select_b <= 1'($urandom);
        chk(b, dup_pkg::BAUD_CHAR, "baud char");
        repeat (dup_pkg::STUB_LEN) rx(0, b);
        n = 0;
        while (link.target_tx_line === 1'b1 && link.host_tx === 1'b1 && n < 60 * BT) begin
            @(posedge clk);
            n++;
        end
        chk(link.host_tx, 1'b1, "host quiet in pause");
        chk_min(n, (dup_pkg::PAUSE_BITS - 1) * BT, "pause");
        rx(1, b);
        chk(b, dup_pkg::READY_CHAR, "ready char");
        chk(eeprom_jump, 1'b0, "no eeprom jump");
        chk(open_drain, 1'b0, "wire-or cleared");
        $display("test download done");
        sense <= 1'b1;
        repeat (VPP_N - 10) @(posedge clk);
        sense <= 1'b0;
        wait_low(0, 2 * VPP_N, n);
        chk_min(n, 2 * VPP_N, "vpp glitch");
        chk(busy_led, 1'b0, "busy early");
        sense <= 1'b1;
        wait_low(0, 60 * BT, n);
        chk_min(n, VPP_N, "vpp stable");
        chk(busy_led, 1'b1, "busy on");
        for (int i = 0; i < IMG_N; i++) begin
            rx(0, b);
            chk(b, image[i], "data order");
            rx(1, b);
            chk(b, image[i], "echo");
        end
        repeat (BT) @(posedge clk);
        chk(done_led, 1'b1, "done on");
        chk(busy_led, 1'b0, "busy off");
        chk(s_data.size(), IMG_N, "strobes");
        for (int i = 0; i < s_data.size(); i++) begin
            chk(s_addr[i], dup_pkg::PROG_START_ADDR + 16'(i), "address");
            chk(s_data[i], image[i], "programmed");
        end
        chk(emulation_mode, 1'b0, "mode pins ignored");
        $display("test programming done");
        final_report();
    end
endmodule : test_bootstrap_eprom_duplicator
